// >>> hdl/pviu_defs.vh
// Behaviour
// - 27 sources map onto 16 vectors grouped into 8 levels.
// - system mode bit 0 is global enable; cleared means no grant.
// - each level has a mask bit; unmasked levels only are granted.
// - level priority register sets the order of the eight levels.
// - the highest programmed priority level is serviced first.
// - within one level the lowest numbered vector wins.
// - internal sources are fixed to one vector and one level.
// - granted vector number selects the handler address location.
// - vector 12 is level 2; level 3 holds vectors 0, 2, 4, 6.
// - each source has its own enable; disabled sources raise nothing.
// - grant needs global, level, top level, source and in-level priority.
// - normal grant clears global enable, saves pc and flags, branches.
// - return from interrupt restores pc and flags, sets global enable.
// - fast entry takes 6 clock periods, normal entry 22.
// - fast grant swaps pointer and pc, shadows flags, sets fast status.
// - fast return swaps back, restores flags, clears fast status.
// - external pin edges are latched into pending flip-flops.
// - memory timing bit 1 selects internal or external stack.
// - stack pointer is high and low register pair.
// - decrement before push, increment after pop.
`ifndef PVIU_DEFS_VH
`define PVIU_DEFS_VH
`define PVIU_IDX_SRC_EN0   8'hC0
`define PVIU_IDX_SRC_EN1   8'hC1
`define PVIU_IDX_SRC_EN2   8'hC2
`define PVIU_IDX_SRC_EN3   8'hC3
`define PVIU_IDX_PENDING   8'hC4
`define PVIU_IDX_STATUS    8'hC5
`define PVIU_IDX_PTR_LOW   8'hD0
`define PVIU_IDX_PTR_HIGH  8'hD1
`define PVIU_IDX_SP_HIGH   8'hD8
`define PVIU_IDX_SP_LOW    8'hD9
`define PVIU_IDX_LVL_MASK  8'hDD
`define PVIU_IDX_SYS_MODE  8'hDE
`define PVIU_IDX_MEM_TIME  8'hFE
`define PVIU_IDX_LVL_PRIO  8'hFF
`define PVIU_SM_GIE        0
`define PVIU_SM_FAST_EN    1
`define PVIU_SM_FSEL_LO    2
`define PVIU_SM_FSEL_HI    4
`define PVIU_MT_EXT_STACK  1
`define PVIU_PR_DIR        3
`define PVIU_RST_BYTE      8'h00
`define PVIU_NORMAL_CYC    5'd22
`define PVIU_FAST_CYC      5'd6
`endif

// >>> hdl/pviu_top.v
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "pviu_defs.vh"
module pviu_top #(
    parameter N_INT = 19,
    parameter N_EXT = 8
) (
    input  wire        clock_in,
    input  wire        nrst_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [9:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    input  wire [18:0] int_src_in,
    input  wire [7:0]  ext_pin_in,
    input  wire        take_in,
    input  wire        ret_in,
    input  wire        push_in,
    input  wire        pop_in,
    input  wire [15:0] pc_in,
    input  wire [7:0]  flags_in,
    output wire        req_out,
    output reg  [3:0]  vector_out,
    output reg         fast_out,
    output reg         entry_busy_out,
    output reg         entry_done_out,
    output reg  [15:0] pc_load_out,
    output reg         pc_load_valid_out,
    output reg  [7:0]  flags_restore_out,
    output reg         flags_restore_valid_out,
    output reg         fast_status_out,
    output wire [15:0] sp_out,
    output wire        stack_ext_out
);

////////////////////////////////////////////////////////////////////////
// registers
reg  [26:0] src_en_ff;
reg  [7:0]  pend_ff;
reg  [15:0] ptr_ff;
reg  [7:0]  sp_hi_ff;
reg  [7:0]  sp_lo_ff;
reg  [7:0]  mask_ff;
reg  [7:0]  sysm_ff;
reg  [7:0]  memt_ff;
reg  [7:0]  prio_ff;
reg  [7:0]  shadow_ff;
reg  [4:0]  cnt_ff;
reg  [7:0]  sy1_ff;
reg  [7:0]  sy2_ff;
reg  [7:0]  sy3_ff;

wire [7:0]  idx = wb_adr_in[9:2];
wire        wr  = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & wb_sel_in[0];
wire [7:0]  wd  = wb_dat_in[7:0];

////////////////////////////////////////////////////////////////////////
// vector to level table
function [2:0] vec_level;
    input [3:0] v;
    begin
        case (v)
            4'h0, 4'h2, 4'h4, 4'h6: vec_level = 3'd3;
            4'hC:                   vec_level = 3'd2;
            4'h1:                   vec_level = 3'd0;
            4'h3, 4'h5:             vec_level = 3'd1;
            4'h7, 4'h8:             vec_level = 3'd4;
            4'h9, 4'hA:             vec_level = 3'd5;
            4'hB, 4'hD:             vec_level = 3'd6;
            default:                vec_level = 3'd7;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// source gating and vector folding
wire [26:0] src_raw = {pend_ff, int_src_in};
wire [26:0] src_act = src_raw & src_en_ff;
reg  [15:0] vec_act;
reg  [7:0]  lvl_act;
integer     i;
always @* begin
    vec_act = 16'h0000;
    for (i = 0; i < 27; i = i + 1)
        if (src_act[i])
            vec_act[i % 16] = 1'b1;
    lvl_act = 8'h00;
    for (i = 0; i < 16; i = i + 1)
        if (vec_act[i])
            lvl_act[vec_level(i[3:0])] = 1'b1;
    lvl_act = lvl_act & mask_ff;
end

////////////////////////////////////////////////////////////////////////
// level then vector arbitration
reg  [2:0]  win_lvl;
reg  [3:0]  win_vec;
reg         win_ok;
reg         vec_ok;
reg  [2:0]  cand;
integer     k;
always @* begin
    win_lvl = 3'd0;
    win_ok  = 1'b0;
    cand    = 3'd0;
    for (k = 7; k >= 0; k = k - 1) begin
        if (prio_ff[`PVIU_PR_DIR])
            cand = prio_ff[2:0] - k[2:0];
        else
            cand = prio_ff[2:0] + k[2:0];
        if (lvl_act[cand]) begin
            win_lvl = cand;
            win_ok  = 1'b1;
        end
    end
    win_vec = 4'h0;
    vec_ok  = 1'b0;
    for (k = 15; k >= 0; k = k - 1)
        if (vec_act[k] && vec_level(k[3:0]) == win_lvl) begin
            win_vec = k[3:0];
            vec_ok  = 1'b1;
        end
end

wire idle  = ~entry_busy_out;
wire grant = idle & sysm_ff[`PVIU_SM_GIE] & win_ok & vec_ok;
wire fast_hit = sysm_ff[`PVIU_SM_FAST_EN]
              & (sysm_ff[`PVIU_SM_FSEL_HI:`PVIU_SM_FSEL_LO] == win_lvl);
assign req_out = grant;
wire take = grant & take_in;
wire fret = ret_in & fast_status_out;

////////////////////////////////////////////////////////////////////////
// entry sequencer
always @(posedge clock_in) begin
    if (!nrst_in) begin
        entry_busy_out          <= 1'b0;
        entry_done_out          <= 1'b0;
        cnt_ff                  <= 5'd0;
        vector_out              <= 4'h0;
        fast_out                <= 1'b0;
        pc_load_out             <= 16'h0000;
        pc_load_valid_out       <= 1'b0;
        flags_restore_out       <= `PVIU_RST_BYTE;
        flags_restore_valid_out <= 1'b0;
        fast_status_out         <= 1'b0;
        shadow_ff               <= `PVIU_RST_BYTE;
    end else begin
        entry_done_out          <= 1'b0;
        pc_load_valid_out       <= 1'b0;
        flags_restore_valid_out <= 1'b0;
        if (take) begin
            entry_busy_out <= 1'b1;
            vector_out     <= win_vec;
            fast_out       <= fast_hit;
            if (fast_hit) begin
                cnt_ff          <= `PVIU_FAST_CYC - 5'd1;
                pc_load_out     <= ptr_ff;
                shadow_ff       <= flags_in;
                fast_status_out <= 1'b1;
            end else
                cnt_ff <= `PVIU_NORMAL_CYC - 5'd1;
        end else if (entry_busy_out) begin
            if (cnt_ff == 5'd1) begin
                entry_busy_out    <= 1'b0;
                entry_done_out    <= 1'b1;
                pc_load_valid_out <= fast_out;
            end
            cnt_ff <= cnt_ff - 5'd1;
        end else if (fret) begin
            pc_load_out             <= ptr_ff;
            pc_load_valid_out       <= 1'b1;
            flags_restore_out       <= shadow_ff;
            flags_restore_valid_out <= 1'b1;
            fast_status_out         <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// external edge capture
always @(posedge clock_in) begin
    if (!nrst_in) begin
        sy1_ff <= 8'h00;
        sy2_ff <= 8'h00;
        sy3_ff <= 8'h00;
    end else begin
        sy1_ff <= ext_pin_in;
        sy2_ff <= sy1_ff;
        sy3_ff <= sy2_ff;
    end
end
wire [7:0] ext_rise = sy2_ff & ~sy3_ff;

always @(posedge clock_in) begin
    if (!nrst_in)
        pend_ff <= 8'h00;
    else if (wr && idx == `PVIU_IDX_PENDING)
        pend_ff <= (pend_ff & ~wd) | ext_rise;
    else
        pend_ff <= pend_ff | ext_rise;
end

////////////////////////////////////////////////////////////////////////
// stack pointer
wire [15:0] sp_cur = {sp_hi_ff, sp_lo_ff};
reg  [15:0] nxt_sp;
always @* begin
    nxt_sp = sp_cur;
    if (push_in && !pop_in)
        nxt_sp = sp_cur - 16'h0001;
    else if (pop_in && !push_in)
        nxt_sp = sp_cur + 16'h0001;
end
assign sp_out        = sp_cur;
assign stack_ext_out = memt_ff[`PVIU_MT_EXT_STACK];

////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge clock_in) begin
    if (!nrst_in) begin
        src_en_ff <= 27'h0000000;
        ptr_ff    <= 16'h0000;
        sp_hi_ff  <= `PVIU_RST_BYTE;
        sp_lo_ff  <= `PVIU_RST_BYTE;
        mask_ff   <= `PVIU_RST_BYTE;
        sysm_ff   <= `PVIU_RST_BYTE;
        memt_ff   <= `PVIU_RST_BYTE;
        prio_ff   <= `PVIU_RST_BYTE;
    end else begin
        if (wr) begin
            case (idx)
                `PVIU_IDX_SRC_EN0:  src_en_ff[7:0]   <= wd;
                `PVIU_IDX_SRC_EN1:  src_en_ff[15:8]  <= wd;
                `PVIU_IDX_SRC_EN2:  src_en_ff[23:16] <= wd;
                `PVIU_IDX_SRC_EN3:  src_en_ff[26:24] <= wd[2:0];
                `PVIU_IDX_PTR_LOW:  ptr_ff[7:0]      <= wd;
                `PVIU_IDX_PTR_HIGH: ptr_ff[15:8]     <= wd;
                `PVIU_IDX_LVL_MASK: mask_ff          <= wd;
                `PVIU_IDX_SYS_MODE: sysm_ff          <= wd;
                `PVIU_IDX_MEM_TIME: memt_ff          <= wd;
                `PVIU_IDX_LVL_PRIO: prio_ff          <= wd;
                default: ;
            endcase
        end
        // sw stack pointer write, hardware push or pop wins
        if (push_in ^ pop_in) begin
            sp_hi_ff <= nxt_sp[15:8];
            sp_lo_ff <= nxt_sp[7:0];
        end else if (wr && idx == `PVIU_IDX_SP_HIGH)
            sp_hi_ff <= wd;
        else if (wr && idx == `PVIU_IDX_SP_LOW)
            sp_lo_ff <= wd;
        // hardware events win over a concurrent mode write
        if (take)
            sysm_ff[`PVIU_SM_GIE] <= 1'b0;
        else if (ret_in && !entry_busy_out)
            sysm_ff[`PVIU_SM_GIE] <= 1'b1;
        if (take && fast_hit)
            ptr_ff <= pc_in;
        else if (fret && !entry_busy_out)
            ptr_ff <= pc_in;
    end
end

////////////////////////////////////////////////////////////////////////
// bus read and ack
reg [7:0] rd;
always @* begin
    case (idx)
        `PVIU_IDX_SRC_EN0:  rd = src_en_ff[7:0];
        `PVIU_IDX_SRC_EN1:  rd = src_en_ff[15:8];
        `PVIU_IDX_SRC_EN2:  rd = src_en_ff[23:16];
        `PVIU_IDX_SRC_EN3:  rd = {5'b00000, src_en_ff[26:24]};
        `PVIU_IDX_PENDING:  rd = pend_ff;
        `PVIU_IDX_STATUS:   rd = {2'b00, fast_status_out, entry_busy_out, vector_out};
        `PVIU_IDX_PTR_LOW:  rd = ptr_ff[7:0];
        `PVIU_IDX_PTR_HIGH: rd = ptr_ff[15:8];
        `PVIU_IDX_SP_HIGH:  rd = sp_hi_ff;
        `PVIU_IDX_SP_LOW:   rd = sp_lo_ff;
        `PVIU_IDX_LVL_MASK: rd = mask_ff;
        `PVIU_IDX_SYS_MODE: rd = sysm_ff;
        `PVIU_IDX_MEM_TIME: rd = memt_ff;
        `PVIU_IDX_LVL_PRIO: rd = prio_ff;
        default:            rd = 8'h00;
    endcase
end

always @(posedge clock_in) begin
    if (!nrst_in) begin
        wb_ack_out <= 1'b0;
        wb_dat_out <= 32'h00000000;
    end else begin
        wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
        if (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in)
            wb_dat_out <= {24'h000000, rd};
    end
end

endmodule // pviu_top

// >>> sim/pviu_chk.sv
`timescale 1ns/1ps
module pviu_chk (
    input wire        clock_in,
    input wire        nrst_in,
    input wire        wb_cyc_in,
    input wire        wb_stb_in,
    input wire        wb_ack_out,
    input wire        req_out,
    input wire        take_in,
    input wire        ret_in,
    input wire        push_in,
    input wire        pop_in,
    input wire        fast_out,
    input wire        entry_busy_out,
    input wire        entry_done_out,
    input wire        fast_status_out,
    input wire        pc_load_valid_out,
    input wire [15:0] sp_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    sequence s_take; req_out && take_in; endsequence
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    a_busy_no_req: assert property (entry_busy_out |-> !req_out) else $error("req while busy");
    a_take_busy: assert property (s_take |=> entry_busy_out [*5]) else $error("entry not busy");
    a_fast_len: assert property (s_take ##1 fast_out |-> ##5 entry_done_out) else $error("fast length");
    a_normal_len: assert property (s_take ##1 !fast_out |-> ##21 entry_done_out) else $error("normal length");
    a_fast_status: assert property (s_take ##1 fast_out |-> fast_status_out) else $error("no fast status");
    a_fast_return: assert property (ret_in && fast_status_out && !entry_busy_out
        |=> !fast_status_out && pc_load_valid_out) else $error("fast return");
    a_push_dec: assert property (push_in && !pop_in |=> sp_out == $past(sp_out) - 16'h0001) else $error("push");
    a_pop_inc: assert property (pop_in && !push_in |=> sp_out == $past(sp_out) + 16'h0001) else $error("pop");
    c_fast: cover property (s_take ##1 fast_out);
    c_normal: cover property (s_take ##1 !fast_out);
    c_fast_ret: cover property (ret_in && fast_status_out);
endmodule // pviu_chk
bind pviu_top pviu_chk pviu_chk_inst (.clock_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out, .req_out,
    .take_in, .ret_in, .push_in, .pop_in, .fast_out, .entry_busy_out, .entry_done_out, .fast_status_out,
    .pc_load_valid_out, .sp_out);

// >>> sim/pviu_core_model.sv
`timescale 1ns/1ps
module pviu_core_model (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        req_out,
    input  wire logic        fast_out,
    input  wire logic        fast_status_out,
    input  wire logic        take_en,
    input  wire logic        ret_cmd,
    output logic             take_in,
    output logic             ret_in,
    output logic             push_in,
    output logic             pop_in,
    output logic [15:0]      pc_in,
    output logic [7:0]       flags_in
);
    logic [1:0] push_cnt_ff;
    logic [1:0] pop_cnt_ff;
    assign pc_in = 16'h1234;
    assign flags_in = 8'h5A;
    always @(posedge clock_in) begin
        if (!nrst_in) begin
            {take_in, ret_in, push_in, pop_in} <= 4'h0;
            push_cnt_ff <= 2'h0;
            pop_cnt_ff <= 2'h0;
        end else begin
            take_in <= take_en && req_out && !take_in;
            ret_in <= ret_cmd;
            // pc low, pc high, flags saved on normal entry
            push_cnt_ff <= take_in ? 2'h3 : push_cnt_ff - {1'h0, push_cnt_ff != 2'h0};
            push_in <= (push_cnt_ff != 2'h0) && !fast_out;
            pop_cnt_ff <= (ret_cmd && !fast_status_out) ? 2'h3 : pop_cnt_ff - {1'h0, pop_cnt_ff != 2'h0};
            pop_in <= pop_cnt_ff != 2'h0;
        end
    end
endmodule // pviu_core_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clock_in = '0, nrst_in = '0, wb_cyc_in = '0, wb_stb_in = '0, wb_we_in = '0;
    logic [9:0]  wb_adr_in = '0;
    logic [3:0]  wb_sel_in = 4'hF;
    logic [31:0] wb_dat_in = '0, wb_dat_out;
    logic [18:0] int_src_in = '0;
    logic [7:0]  ext_pin_in = '0, flags_in, flags_restore_out, rd;
    logic [15:0] pc_in, pc_load_out, sp_out;
    logic [3:0]  vector_out;
    logic        take_in, ret_in, push_in, pop_in, req_out, fast_out, entry_busy_out, entry_done_out;
    logic        pc_load_valid_out, flags_restore_valid_out, fast_status_out, stack_ext_out, wb_ack_out;
    logic        take_en = '0, ret_cmd = '0;
    int          fail_count = 0, total_checks = 0, cycles = 0;
    pviu_top pviu_top_inst (.clock_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .int_src_in, .ext_pin_in, .take_in, .ret_in, .push_in,
        .pop_in, .pc_in, .flags_in, .req_out, .vector_out, .fast_out, .entry_busy_out, .entry_done_out,
        .pc_load_out, .pc_load_valid_out, .flags_restore_out, .flags_restore_valid_out, .fast_status_out,
        .sp_out, .stack_ext_out);
    pviu_core_model pviu_core_model_inst (.clock_in, .nrst_in, .req_out, .fast_out, .fast_status_out,
        .take_en, .ret_cmd, .take_in, .ret_in, .push_in, .pop_in, .pc_in, .flags_in);
    always #50 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input [7:0] idx, input w, input [7:0] d);
        wb_cyc_in <= 1'h1; wb_stb_in <= 1'h1; wb_we_in <= w;
        wb_adr_in <= {idx, 2'h0}; wb_dat_in <= {24'h0, d};
        @(posedge clock_in);
        while (wb_ack_out !== 1'h1) @(posedge clock_in);
        rd = wb_dat_out[7:0];
        wb_cyc_in <= 1'h0; wb_stb_in <= 1'h0;
        @(posedge clock_in);
    endtask
    task take_one;
        take_en <= 1'h1;
        @(posedge clock_in);
        while (entry_done_out !== 1'h1) @(posedge clock_in);
        take_en <= 1'h0;
    endtask
    task ret_one;
        ret_cmd <= 1'h1;
        @(posedge clock_in);
        ret_cmd <= 1'h0;
        repeat (6) @(posedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////
    task t_regs;
        wb(8'hDE, 0, 8'h00); chk(rd, 16'h0000);
        wb(8'hDD, 1, 8'hA5); wb(8'hDD, 0, 8'h00); chk(rd, 16'h00A5);
        wb(8'hFE, 1, 8'h02); chk(stack_ext_out, 16'h0001);
        wb(8'hFE, 1, 8'h00); chk(stack_ext_out, 16'h0000);
        wb(8'h80, 1, 8'hFF); wb(8'h80, 0, 8'h00); chk(rd, 16'h0000);
        $display("t_regs done");
    endtask
    task t_gate;
        wb(8'hC0, 1, 8'h01); int_src_in <= 19'h00001; wb(8'hDD, 1, 8'h08);
        chk(req_out, 16'h0000);
        wb(8'hDE, 1, 8'h01); chk(req_out, 16'h0001);
        wb(8'hDD, 1, 8'hF7); chk(req_out, 16'h0000);
        wb(8'hDD, 1, 8'h08); wb(8'hC0, 1, 8'h00); chk(req_out, 16'h0000);
        $display("t_gate done");
    endtask
    task t_order(input [7:0] prio, input [18:0] src, input [3:0] vec);
        int_src_in <= src; wb(8'hFF, 1, prio);
        take_one; chk(vector_out, {12'h000, vec});
        chk(sp_out, 16'h00FD);
        wb(8'hDE, 0, 8'h00); chk(rd, 16'h0000);
        ret_one; chk(sp_out, 16'h0100);
        wb(8'hDE, 0, 8'h00); chk(rd, 16'h0001);
        $display("t_order done");
    endtask
    task t_fast;
        wb(8'hD0, 1, 8'hBC); wb(8'hD1, 1, 8'h0A); wb(8'hDE, 1, 8'h0F);
        take_one; chk(fast_out, 16'h0001); chk(pc_load_out, 16'h0ABC);
        chk(fast_status_out, 16'h0001); chk(sp_out, 16'h0100);
        ret_cmd <= 1'h1; @(posedge clock_in); ret_cmd <= 1'h0;
        while (flags_restore_valid_out !== 1'h1) @(posedge clock_in);
        chk(flags_restore_out, 16'h005A); chk(pc_load_out, 16'h1234);
        chk(fast_status_out, 16'h0000);
        int_src_in <= 19'h00000; wb(8'hDE, 1, 8'h00);
        $display("t_fast done");
    endtask
    task t_pin;
        wb(8'hC2, 1, 8'h08); wb(8'hDD, 1, 8'h02); wb(8'hDE, 1, 8'h01);
        ext_pin_in <= 8'h01; repeat (2) @(posedge clock_in);
        ext_pin_in <= 8'h00; repeat (4) @(posedge clock_in);
        wb(8'hC4, 0, 8'h00); chk(rd, 16'h0001);
        take_one; chk(vector_out, 16'h0003);
        wb(8'hC4, 1, 8'h01); wb(8'hC4, 0, 8'h00); chk(rd, 16'h0000);
        ret_one; chk(req_out, 16'h0000);
        $display("t_pin done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'h1;
        @(posedge clock_in);
        t_regs;
        t_gate;
        wb(8'hD8, 1, 8'h01); wb(8'hD9, 1, 8'h00); wb(8'hC0, 1, 8'h05);
        wb(8'hC1, 1, 8'h10); wb(8'hDD, 1, 8'h0C);
        t_order(8'h02, 19'h01005, 4'hC);
        t_order(8'h03, 19'h01005, 4'h0);
        t_order(8'h04, 19'h01004, 4'hC);
        t_order(8'h0C, 19'h01004, 4'h2);
        t_fast;
        t_pin;
        wrap_up;
    end
endmodule // testbench
